// ==== sdc_drive_cfg.sv ====
// Local design decisions: the address-and-strobe port and the placing of the registers.
`include "sdc_defs.svh"
// Summary of operation
// - one type bit per input: 0 opens when active, 1 closes when active
// - opening contact: low level means reached, feedback bit cleared
// - closing contact: high level means reached, feedback bit set
// - used inputs light their lamp while active, per contact polarity
// - resolution codes 0..8 give full step down to 1/256 step
// - run current in 100 mA units, 1..35 valid, code 0 refused
// - after stop and delay expiry, switch to stop current; 0 allowed
// - positioning with boost: boost current during ramps
// - delay codes 0..15 map 1 ms up to 1000 ms
// - boost on uses boost current on ramps in positioning only; boost off keeps run current in motion
// - control area is 8 bytes positioning, 10 bytes motion object
// - feedback area is 12 bytes positioning, 18 bytes motion object
// - motion object mode reports full steps times microstep divisor
module sdc_drive_cfg
  import sdc_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `SDC_CYC_PER_MS
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  sdc_pkg::sdc_addr_t addr,
  input  sdc_pkg::sdc_word_t wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output sdc_pkg::sdc_word_t rdata,
  // motion status from the ramp logic
  input  wire logic        motor_moving,
  input  wire logic        ramp_active,
  // switch inputs and lamps
  input  wire logic [2:0]  switch_inputs,
  output logic [2:0]       limit_fb,
  output logic [2:0]       lamp,
  // power stage settings
  output sdc_pkg::sdc_cur_t current_code,
  output logic [8:0]       ustep_div,
  output logic             param_err,
  output logic [23:0]      usteps_rev,
  output logic [7:0]       ctrl_bytes,
  output logic [7:0]       fb_bytes
);
  import sdc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        mode_mo;
    logic [2:0]  sw_type;
    logic [2:0]  sw_use;
    logic [3:0]  res;
    logic [5:0]  run_i;
    logic [5:0]  stop_i;
    logic [5:0]  boost_i;
    logic [3:0]  dly;
    logic        boost_en;
    logic [15:0] msteps;
    logic        perr;
    logic [2:0]  fb;
    logic [2:0]  lamp;
    logic [23:0] pre;
    logic [9:0]  ms;
    logic        at_stop;
    logic [5:0]  cur;
    logic [8:0]  div;
    logic [23:0] usteps;
    logic [7:0]  ctrl_b;
    logic [7:0]  fb_b;
    logic [31:0] rdata;
  } sdc_state_t;

  sdc_state_t s;
  sdc_state_t next_s;
  sdc_ms_t    dly_ms;
  logic [2:0] act;

  localparam logic [23:0] PRE_LAST = 24'(CYC_PER_MS - 1);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // valid current code; run current also refuses zero
  function automatic logic cur_ok(input logic [5:0] c, input logic nz);
    cur_ok = (c <= `SDC_CUR_MAX) && !(nz && c == 6'h00);
  endfunction

  // active level after contact polarity
  function automatic logic [2:0] active_of(input logic [2:0] lvl,
                                           input logic [2:0] typ);
    active_of = ~(lvl ^ typ);
  endfunction

  assign act = active_of(switch_inputs, s.sw_type);

  // ---------------------------------------------------------------
  // delay table
  // ---------------------------------------------------------------
  sdc_delay_rom u_rom (
    .clk  (clk),
    .code (s.dly),
    .ms   (dly_ms)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    // register writes; bad codes keep the old value and flag it
    if (wr) begin
      unique case (addr)
        `SDC_A_MODE:    next_s.mode_mo = wdata[0];
        `SDC_A_SWTYPE:  next_s.sw_type = wdata[2:0];
        `SDC_A_SWUSE:   next_s.sw_use = wdata[2:0];
        `SDC_A_RES: begin
          if (wdata[31:4] == 28'h0 && wdata[3:0] <= `SDC_RES_MAX) begin
            next_s.res = wdata[3:0];
          end else begin
            next_s.perr = 1'b1;
          end
        end
        `SDC_A_RUN: begin
          if (wdata[31:6] == 26'h0 && cur_ok(wdata[5:0], 1'b1)) begin
            next_s.run_i = wdata[5:0];
          end else begin
            next_s.perr = 1'b1;
          end
        end
        `SDC_A_STOP: begin
          if (wdata[31:6] == 26'h0 && cur_ok(wdata[5:0], 1'b0)) begin
            next_s.stop_i = wdata[5:0];
          end else begin
            next_s.perr = 1'b1;
          end
        end
        `SDC_A_BOOST: begin
          if (wdata[31:6] == 26'h0 && cur_ok(wdata[5:0], 1'b0)) begin
            next_s.boost_i = wdata[5:0];
          end else begin
            next_s.perr = 1'b1;
          end
        end
        `SDC_A_DELAY:   next_s.dly = wdata[3:0];
        `SDC_A_BOOSTEN: next_s.boost_en = wdata[0];
        `SDC_A_MSTEPS:  next_s.msteps = wdata[15:0];
        // write one clears the error, but a refused write never lands
        // here in the same cycle, so no set is lost
        `SDC_A_STATUS: begin
          if (wdata[`SDC_ST_PERR]) begin
            next_s.perr = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // raw level is the feedback bit: low clears it, high sets it
    next_s.fb = switch_inputs;
    next_s.lamp = act & s.sw_use;

    // stop delay: restarted by any motion, counts whole milliseconds
    if (motor_moving) begin
      next_s.pre = 24'h0;
      next_s.ms = 10'h0;
      next_s.at_stop = 1'b0;
    end else if (!s.at_stop) begin
      if (s.pre == PRE_LAST) begin
        next_s.pre = 24'h0;
        next_s.ms = s.ms + 10'h1;
      end else begin
        next_s.pre = s.pre + 24'h1;
      end
      next_s.at_stop = (s.ms >= dly_ms);
    end

    // current selection; boost exists only in positioning
    if (motor_moving) begin
      if (!s.mode_mo && s.boost_en && ramp_active) begin
        next_s.cur = s.boost_i;
      end else begin
        next_s.cur = s.run_i;
      end
    end else if (s.at_stop) begin
      next_s.cur = s.stop_i;
    end else begin
      next_s.cur = s.run_i;
    end

    next_s.div = 9'(9'h1 << s.res);
    // full steps times divisor, a shift since the divisor is 2^res
    next_s.usteps = s.mode_mo ? 24'({8'h0, s.msteps} << s.res)
                              : 24'h0;
    next_s.ctrl_b = s.mode_mo ? `SDC_CTRL_MO : `SDC_CTRL_PM;
    next_s.fb_b = s.mode_mo ? `SDC_FB_MO : `SDC_FB_PM;

    // read data stand one cycle only; unmapped reads give zero
    next_s.rdata = 32'h0;
    if (rd) begin
      unique case (addr)
        `SDC_A_MODE:    next_s.rdata = {31'h0, s.mode_mo};
        `SDC_A_SWTYPE:  next_s.rdata = {29'h0, s.sw_type};
        `SDC_A_SWUSE:   next_s.rdata = {29'h0, s.sw_use};
        `SDC_A_RES:     next_s.rdata = {28'h0, s.res};
        `SDC_A_RUN:     next_s.rdata = {26'h0, s.run_i};
        `SDC_A_STOP:    next_s.rdata = {26'h0, s.stop_i};
        `SDC_A_BOOST:   next_s.rdata = {26'h0, s.boost_i};
        `SDC_A_DELAY:   next_s.rdata = {28'h0, s.dly};
        `SDC_A_BOOSTEN: next_s.rdata = {31'h0, s.boost_en};
        `SDC_A_MSTEPS:  next_s.rdata = {16'h0, s.msteps};
        `SDC_A_STATUS:  next_s.rdata = {18'h0, s.cur, s.at_stop,
                                        s.fb, act, s.perr};
        `SDC_A_USTEPS:  next_s.rdata = {8'h0, s.usteps};
        `SDC_A_AREA:    next_s.rdata = {16'h0, s.fb_b, s.ctrl_b};
        default:        next_s.rdata = 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.res <= `SDC_RST_RES;
      s.run_i <= `SDC_RST_RUN;
      s.stop_i <= `SDC_RST_STOP;
      s.boost_i <= `SDC_RST_BOOST;
      s.dly <= `SDC_RST_DELAY;
      s.msteps <= `SDC_RST_MSTEPS;
      s.cur <= `SDC_RST_RUN;
      s.div <= 9'h001;
      s.ctrl_b <= `SDC_CTRL_PM;
      s.fb_b <= `SDC_FB_PM;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign rdata = s.rdata;
  assign limit_fb = s.fb;
  assign lamp = s.lamp;
  assign current_code = s.cur;
  assign ustep_div = s.div;
  assign param_err = s.perr;
  assign usteps_rev = s.usteps;
  assign ctrl_bytes = s.ctrl_b;
  assign fb_bytes = s.fb_b;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence bad_res_wr;
    wr && addr == `SDC_A_RES && wdata > 32'h8;
  endsequence

  sequence zero_run_wr;
    wr && addr == `SDC_A_RUN && wdata == 32'h0;
  endsequence

  a_res_refused: assert property (
    bad_res_wr |=> s.perr && s.res == $past(s.res))
    else $error("bad resolution code accepted");

  a_run_zero: assert property (
    zero_run_wr |=> param_err && s.run_i == $past(s.run_i))
    else $error("zero run current accepted");

  a_fb_opening: assert property (
    !s.sw_type[0] && !switch_inputs[0] |=> !limit_fb[0])
    else $error("opening contact feedback not cleared");

  a_fb_closing: assert property (
    s.sw_type[1] && switch_inputs[1] |=> limit_fb[1])
    else $error("closing contact feedback not set");

  a_lamp_level: assert property (
    ##1 lamp == ($past(s.sw_use) &
                 ~($past(switch_inputs) ^ $past(s.sw_type))))
    else $error("lamp does not follow active input");

  a_stop_hold: assert property (
    $fell(motor_moving) |-> !s.at_stop ##1 current_code == $past(s.run_i))
    else $error("stop current taken without delay");

  a_stop_current: assert property (
    s.at_stop && !motor_moving |=> current_code == $past(s.stop_i))
    else $error("stop current not applied after delay");

  a_boost_ramp: assert property (
    motor_moving && ramp_active && s.boost_en && !s.mode_mo
      |=> current_code == $past(s.boost_i))
    else $error("boost current missing on ramp");

  a_no_boost: assert property (
    motor_moving && !s.boost_en |=> current_code == $past(s.run_i))
    else $error("run current not used in motion");

  a_area_size: assert property (
    ##1 ctrl_bytes == ($past(s.mode_mo) ? 8'h0a : 8'h08) &&
        fb_bytes == ($past(s.mode_mo) ? 8'h12 : 8'h0c))
    else $error("area size wrong for mode");

  a_usteps_rev: assert property (
    s.mode_mo && s.res == 4'h3 |=> usteps_rev == 24'($past(s.msteps)) * 24'h8)
    else $error("steps per revolution wrong");

  a_read_once: assert property (
    !rd |=> rdata == 32'h0)
    else $error("read data outside read slot");

  sequence err_clear_wr;
    wr && addr == `SDC_A_STATUS && wdata[`SDC_ST_PERR];
  endsequence

  a_err_clear: assert property (
    err_clear_wr |=> !param_err)
    else $error("error flag not cleared");

  a_res_legal: assert property (
    s.res <= `SDC_RES_MAX)
    else $error("resolution code out of range");

  a_run_legal: assert property (
    s.run_i != 6'h00 && s.run_i <= `SDC_CUR_MAX)
    else $error("run current code out of range");

  a_div_full: assert property (
    s.res == 4'h0 |=> ustep_div == 9'h001)
    else $error("full step divisor wrong");

  a_div_fine: assert property (
    s.res == 4'h8 |=> ustep_div == 9'h100)
    else $error("finest step divisor wrong");

  a_delay_top: assert property (
    s.dly == 4'hf |=> dly_ms == 10'h3e8)
    else $error("longest current delay wrong");

  a_boost_mo: assert property (
    motor_moving && s.mode_mo |=> current_code == $past(s.run_i))
    else $error("boost current outside positioning");
endmodule

// ==== sdc_defs.svh ====
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH

// ---------------------------------------------------------------
// register indices on the plain register port
// ---------------------------------------------------------------
`define SDC_A_MODE     4'h0
`define SDC_A_SWTYPE   4'h1
`define SDC_A_SWUSE    4'h2
`define SDC_A_RES      4'h3
`define SDC_A_RUN      4'h4
`define SDC_A_STOP     4'h5
`define SDC_A_BOOST    4'h6
`define SDC_A_DELAY    4'h7
`define SDC_A_BOOSTEN  4'h8
`define SDC_A_MSTEPS   4'h9
`define SDC_A_STATUS   4'ha
`define SDC_A_USTEPS   4'hb
`define SDC_A_AREA     4'hc

// ---------------------------------------------------------------
// status word fields
// ---------------------------------------------------------------
`define SDC_ST_PERR    0
`define SDC_ST_ACT_LO  1
`define SDC_ST_FB_LO   4
`define SDC_ST_STOP    7
`define SDC_ST_CUR_LO  8

// ---------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------
`define SDC_RST_RES     4'h5
`define SDC_RST_RUN     6'h19
`define SDC_RST_STOP    6'h00
`define SDC_RST_BOOST   6'h00
`define SDC_RST_DELAY   4'h9
`define SDC_RST_MSTEPS  16'h00c8
`define SDC_RES_MAX     4'h8
`define SDC_CUR_MAX     6'h23
`define SDC_CTRL_PM     8'h08
`define SDC_CTRL_MO     8'h0a
`define SDC_FB_PM       8'h0c
`define SDC_FB_MO       8'h12

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SDC_CLK_HZ      10000000
`define SDC_MS_PER_S    1000
`define SDC_CYC_PER_MS  (`SDC_CLK_HZ / `SDC_MS_PER_S)

`endif

// ==== sdc_pkg.sv ====
package sdc_pkg;
  typedef logic [3:0]  sdc_addr_t;
  typedef logic [31:0] sdc_word_t;
  typedef logic [5:0]  sdc_cur_t;
  typedef logic [9:0]  sdc_ms_t;
endpackage

// ==== sdc_delay_rom.sv ====
module sdc_delay_rom
  import sdc_pkg::*;
(
  // clock
  input  wire logic       clk,
  // lookup
  input  wire logic [3:0] code,
  output sdc_pkg::sdc_ms_t ms
);
  // ---------------------------------------------------------------
  // delay code to milliseconds, registered
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    unique case (code)
      4'h0: ms <= 10'h001;
      4'h1: ms <= 10'h002;
      4'h2: ms <= 10'h004;
      4'h3: ms <= 10'h006;
      4'h4: ms <= 10'h008;
      4'h5: ms <= 10'h00a;
      4'h6: ms <= 10'h00c;
      4'h7: ms <= 10'h00e;
      4'h8: ms <= 10'h010;
      4'h9: ms <= 10'h014;
      4'ha: ms <= 10'h028;
      4'hb: ms <= 10'h03c;
      4'hc: ms <= 10'h064;
      4'hd: ms <= 10'h0c8;
      4'he: ms <= 10'h1f4;
      4'hf: ms <= 10'h3e8;
    endcase
  end
endmodule

// ==== sdc_cpu_model.sv ====
module sdc_cpu_model (
  // clock
  input  wire logic          clk,
  // register port
  output sdc_pkg::sdc_addr_t addr,
  output sdc_pkg::sdc_word_t wdata,
  output logic               wr,
  output logic               rd,
  input  sdc_pkg::sdc_word_t rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import sdc_pkg::*;

  // ---------------------------------------------------
  // idle bus at time zero, strobes low
  // ---------------------------------------------------
  initial begin
    addr  = 4'h0;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // one-cycle write; data scrambled after release
  task automatic put(input sdc_addr_t a, input sdc_word_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d; // stale data must not be relied on
  endtask

  // one-cycle read; data stands only in the next cycle
  task automatic get(input sdc_addr_t a, output sdc_word_t d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    // data stand until the next edge; take them there
    @(posedge clk);
    d = rdata;
  endtask
endmodule

// ==== sdc_drive_cfg_bench.sv ====
module sdc_drive_cfg_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sdc_pkg::*;

  // small ms count keeps the longest delay to a few thousand cycles
  localparam int CPM = 4;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  sdc_addr_t   addr;
  sdc_word_t   wdata;
  logic        wr;
  logic        rd;
  sdc_word_t   rdata;
  logic        motor_moving;
  logic        ramp_active;
  logic [2:0]  switch_inputs;
  logic [2:0]  limit_fb;
  logic [2:0]  lamp;
  sdc_cur_t    current_code;
  logic [8:0]  ustep_div;
  logic        param_err;
  logic [23:0] usteps_rev;
  logic [7:0]  ctrl_bytes;
  logic [7:0]  fb_bytes;
  int          n_fail = 0;
  int          samples_checked = 0;
  logic [31:0] seed = 32'hefc4;
  int          ms_tab [16] = '{1, 2, 4, 6, 8, 10, 12, 14, 16, 20, 40, 60,
                               100, 200, 500, 1000};

  // ---------------------------------------------------
  // clock, partner and design
  // ---------------------------------------------------
  always #50 clk = ~clk;

  sdc_cpu_model cpu (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
                     .rd(rd), .rdata(rdata));

  sdc_drive_cfg #(.CYC_PER_MS(CPM)) DUT (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .motor_moving(motor_moving), .ramp_active(ramp_active),
    .switch_inputs(switch_inputs), .limit_fb(limit_fb), .lamp(lamp),
    .current_code(current_code), .ustep_div(ustep_div),
    .param_err(param_err), .usteps_rev(usteps_rev),
    .ctrl_bytes(ctrl_bytes), .fb_bytes(fb_bytes));

  // ---------------------------------------------------
  // helpers
  // ---------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic rchk(input sdc_addr_t a, input logic [31:0] exp);
    sdc_word_t d;
    cpu.get(a, d);
    check(d, exp);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog: all delays together stay well below this
  initial begin
    tick(60000);
    n_fail++;
    stop_test;
  end

  // ---------------------------------------------------
  // main sequence
  // ---------------------------------------------------
  initial begin
    logic [31:0] t;
    logic [15:0] m;
    int          n;
    int          e;
    motor_moving  <= 1'b0;
    ramp_active   <= 1'b0;
    switch_inputs <= 3'h0;
    tick(6);
    rst <= 1'b0;
    tick(2);
    // reset state and sizes
    check(32'(current_code), 32'd25);
    check(32'(ctrl_bytes), 32'd8);
    check(32'(fb_bytes), 32'd12);
    rchk(4'h3, 32'h5);
    rchk(4'h7, 32'h9);
    rchk(4'hc, 32'h0c08);
    rchk(4'hf, 32'h0);
    // random polarity, use mask and levels
    for (int i = 0; i < 24; i++) begin
      t = xs();
      cpu.put(4'h1, 32'(t[2:0]));
      cpu.put(4'h2, 32'(t[5:3]));
      switch_inputs <= t[8:6];
      tick(2);
      check(32'(limit_fb), 32'(t[8:6]));
      check(32'(lamp), 32'(t[5:3] & ~(t[8:6] ^ t[2:0])));
    end
    // every resolution code in motion object mode
    m = 16'(xs());
    cpu.put(4'h0, 32'h1);
    cpu.put(4'h9, 32'(m));
    for (int r = 0; r <= 8; r++) begin
      cpu.put(4'h3, 32'(r));
      tick(3);
      check(32'(ustep_div), 32'h1 << r);
      check(32'(usteps_rev), (32'(m) << r) & 32'hffffff);
      rchk(4'hb, (32'(m) << r) & 32'hffffff);
    end
    check(32'(ctrl_bytes), 32'd10);
    check(32'(fb_bytes), 32'd18);
    // refused codes keep old value and raise the flag
    cpu.put(4'h3, 32'h9);
    tick(2);
    check(32'(param_err), 32'h1);
    check(32'(ustep_div), 32'h100);
    foreach (ms_tab[k]) begin
      if (k < 2) begin
        cpu.put(4'ha, 32'h1);
        tick(2);
        check(32'(param_err), 32'h0);
        cpu.put(4'h4, k == 0 ? 32'h0 : 32'h24);
        tick(2);
        check(32'(param_err), 32'h1);
        rchk(4'h4, 32'd25);
      end
    end
    cpu.put(4'h4, 32'd35);
    rchk(4'h4, 32'd35);
    // positioning: boost only on ramps when enabled
    cpu.put(4'h0, 32'h0);
    cpu.put(4'h4, 32'd20);
    cpu.put(4'h5, 32'd0);
    cpu.put(4'h6, 32'd7);
    cpu.put(4'h8, 32'h1);
    check(32'(usteps_rev), 32'h0);
    motor_moving <= 1'b1;
    ramp_active  <= 1'b1;
    tick(3);
    check(32'(current_code), 32'd7);
    ramp_active <= 1'b0;
    tick(3);
    check(32'(current_code), 32'd20);
    // boost setting has no effect in motion object mode, nor when disabled in positioning
    cpu.put(4'h0, 32'h1);
    ramp_active <= 1'b1;
    tick(3);
    check(32'(current_code), 32'd20);
    ramp_active <= 1'b0;
    cpu.put(4'h0, 32'h0);
    cpu.put(4'h8, 32'h0);
    ramp_active <= 1'b1;
    tick(3);
    check(32'(current_code), 32'd20);
    ramp_active <= 1'b0;
    // stop current after each delay code (zero stop current allowed)
    for (int c = 0; c < 16; c++) begin
      cpu.put(4'h7, 32'(c));
      motor_moving <= 1'b1;
      tick(2);
      motor_moving <= 1'b0;
      e = ms_tab[c] * CPM;
      n = 0;
      while (current_code !== 6'h00 && n < 5000) begin
        tick(1);
        n++;
      end
      check(32'(n >= e && n <= e + 4), 32'h1);
    end
    // status after the last stop: error still pending, stop current in use
    rchk(4'ha, {25'h1, t[8:6], ~(t[8:6] ^ t[2:0]), 1'b1});
    stop_test;
  end
endmodule
